// *** hdl/turns_counter_wake_control.sv ***
// Turns counter, wake input comparator and low power state control
//
// Operation
// - Wake input above rising level in sleep moves to wake state.
// - Wake input held high keeps wake state; every sample updates count.
// - Rising level is 300 mV plus 50 mV per code step.
// - Falling level is rising minus hysteresis, floored at 100 mV.
// - Count steps of 45 or 180 degrees, chosen by a control field.
// - Count saturates at +2047/-2048 or +511/-512.
// - Saturation sets status bit 0, held until counter reset.
// - Each low power wake-state sample updates count from angle change; samples in sleep are ignored.
// - Change of 180 degrees or more counts as opposite direction.
// - Delta above 135 degrees sets status bit 3.
// - Reset command in control register clears the count.
// - After reset, count is relative to the position at reset.
// - Counting continues in normal mode and low power wake state, not in sleep.
// - Count uses the uncompensated low power angle path.
// - Sleep only when slow and wake input below falling level.
// - Sleep ends on period expiry or wake input high.
`timescale 1ns/1ps
module turns_counter_wake_control (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   input wire logic [turns_pkg::ANGLE_W-1:0] low_power_angle_path,
   input wire logic angle_valid,
   input wire logic [turns_pkg::MV_W-1:0] wake_input_mv,
   input wire logic [2:0] wake_input_rising_level_sel,
   input wire logic [1:0] wake_hysteresis_sel,
   input wire logic [turns_pkg::ANGLE_W-1:0] velocity_limit,
   input wire logic [turns_pkg::CYC_W-1:0] lpm_cycle_cycles,
   input wire logic lpm_request,
   output logic [turns_pkg::COUNT_W-1:0] rotation_counts,
   output logic angle_outputs_enable,
   output logic lpm_wake_state,
   output logic lpm_sleep_state,
   output logic wake_input_high
);
   import turns_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      mode_t mode;
      logic step45;
      logic [ANGLE_W-1:0] last_angle;
      logic have_angle;
      logic signed [POS_W-1:0] pos;
      logic [COUNT_W-1:0] count;
      logic sat_flag;
      logic jump_flag;
      logic fast;
      logic [CYC_W-1:0] cyc;
      logic wake_high;
      logic [15:0] rdata;
      logic ang_en;
      logic wake_o;
      logic sleep_o;
   } state_t;

   localparam state_t STATE_RESET = '{
      mode: MODE_NORMAL, step45: STEP_SEL_RESET, last_angle: '0, have_angle: 1'b0,
      pos: '0, count: '0, sat_flag: 1'b0, jump_flag: 1'b0, fast: 1'b0, cyc: '0,
      wake_high: 1'b0, rdata: '0, ang_en: 1'b1, wake_o: 1'b0, sleep_o: 1'b0};

   state_t s;
   state_t next_s;

   logic signed [POS_W-1:0] calc_pos;
   logic [COUNT_W-1:0] calc_count;
   logic calc_sat;
   logic calc_jump;
   logic [ANGLE_W-1:0] calc_mag;
   logic [MV_W-1:0] rise_mv;
   logic [MV_W-1:0] hys_mv;
   logic [MV_W-1:0] fall_mv;
   logic cycle_end;
   logic sample;
   logic ctrl_wr;
   logic reset_cmd;

   // ---------------------------------------------------------------
   // Step arithmetic
   // ---------------------------------------------------------------
   turns_step_calc u_step (
      .last_angle(s.last_angle),
      .new_angle(low_power_angle_path),
      .pos(s.pos),
      .step45(s.step45),
      .next_pos(calc_pos),
      .next_count(calc_count),
      .saturated(calc_sat),
      .big_jump(calc_jump),
      .delta_mag(calc_mag)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_s = s;

      rise_mv = RISE_BASE_MV + 10'(RISE_STEP_MV * wake_input_rising_level_sel);
      unique case (wake_hysteresis_sel)
         2'h0: hys_mv = HYS_0_MV;
         2'h1: hys_mv = HYS_1_MV;
         2'h2: hys_mv = HYS_2_MV;
         2'h3: hys_mv = HYS_3_MV;
      endcase
      if (rise_mv < hys_mv + FALL_FLOOR_MV) begin
         fall_mv = FALL_FLOOR_MV;
      end else begin
         fall_mv = rise_mv - hys_mv;
      end
      if (wake_input_mv > rise_mv) begin
         next_s.wake_high = 1'b1;
      end else if (wake_input_mv < fall_mv) begin
         next_s.wake_high = 1'b0;
      end

      // Period counter runs in every mode
      cycle_end = (s.cyc >= lpm_cycle_cycles - 24'h000001);
      next_s.cyc = cycle_end ? '0 : s.cyc + 24'h000001;

      // Sample in normal and wake states
      // Count from low power angle path
      sample = angle_valid && (s.mode != MODE_SLEEP);

      ctrl_wr = reg_wr && (reg_addr == DEVICE_CONTROL_OFS);
      reset_cmd = ctrl_wr && (reg_wdata[CMD_LSB +: CMD_W] == TURNS_RESET_CMD);
      if (ctrl_wr) begin
         next_s.step45 = reg_wdata[STEP_SEL_BIT];
      end

      if (sample) begin
         next_s.last_angle = low_power_angle_path;
         next_s.have_angle = 1'b1;
         if (s.have_angle) begin
            next_s.pos = calc_pos;
            next_s.count = calc_count;
            if (calc_mag > velocity_limit) begin
               next_s.fast = 1'b1;
            end
         end
      end

      if (reset_cmd) begin
         next_s.pos = '0;
         next_s.count = '0;
         next_s.sat_flag = 1'b0;
         next_s.jump_flag = 1'b0;
         if (sample) begin
            next_s.last_angle = low_power_angle_path;
         end
      end
      if (sample && s.have_angle && calc_sat) begin
         next_s.sat_flag = 1'b1;
      end
      if (sample && s.have_angle && calc_jump) begin
         next_s.jump_flag = 1'b1;
      end
      if (cycle_end) begin
         next_s.fast = 1'b0;
      end

      unique case (s.mode)
         MODE_NORMAL: begin
            if (lpm_request) begin
               next_s.mode = MODE_WAKE;
            end
         end
         MODE_WAKE: begin
            if (!lpm_request) begin
               next_s.mode = MODE_NORMAL;
            // Held awake while wake input high
            // Sleep only when slow and low
            end else if (cycle_end && !s.fast && !s.wake_high) begin
               next_s.mode = MODE_SLEEP;
            end
         end
         MODE_SLEEP: begin
            if (!lpm_request) begin
               next_s.mode = MODE_NORMAL;
            end else if (cycle_end || s.wake_high) begin
               next_s.mode = MODE_WAKE;
            end
         end
      endcase

      // Register read data
      if (reg_rd) begin
         if (reg_addr == DEVICE_CONTROL_OFS) begin
            next_s.rdata = '0;
            next_s.rdata[STEP_SEL_BIT] = s.step45;
         end else if (reg_addr == TURNS_WARNING_STATUS_OFS) begin
            next_s.rdata = '0;
            next_s.rdata[SAT_FLAG_BIT] = s.sat_flag;
            next_s.rdata[JUMP_FLAG_BIT] = s.jump_flag;
         end else begin
            next_s.rdata = '0;
         end
      end

      // No angle outputs in low power mode
      next_s.ang_en = (next_s.mode == MODE_NORMAL);
      next_s.wake_o = (next_s.mode == MODE_WAKE);
      next_s.sleep_o = (next_s.mode == MODE_SLEEP);
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s <= STATE_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata = s.rdata;
   assign rotation_counts = s.count;
   assign angle_outputs_enable = s.ang_en;
   assign lpm_wake_state = s.wake_o;
   assign lpm_sleep_state = s.sleep_o;
   assign wake_input_high = s.wake_high;
endmodule

// *** hdl/turns_pkg.sv ***
// Constants and register layout of the turns counter and wake control block
package turns_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] DEVICE_CONTROL_OFS = 8'h1E;
   localparam logic [7:0] TURNS_WARNING_STATUS_OFS = 8'h26;
   localparam int CMD_LSB = 0;
   localparam int CMD_W = 4;
   localparam int STEP_SEL_BIT = 8;
   localparam int SAT_FLAG_BIT = 0;
   localparam int JUMP_FLAG_BIT = 3;
   localparam logic [3:0] TURNS_RESET_CMD = 4'h1;
   localparam logic STEP_SEL_RESET = 1'b1;

   // ---------------------------------------------------------------
   // Angle and count arithmetic
   // ---------------------------------------------------------------
   localparam int ANGLE_W = 12;
   localparam int ANGLE_FULL = 4096;
   localparam int FULL_DEG = 360;
   localparam int JUMP_DEG = 135;
   localparam logic [11:0] JUMP_LIMIT = 12'(JUMP_DEG * ANGLE_FULL / FULL_DEG);
   localparam int COUNT_W = 12;
   localparam int POS_W = 24;
   localparam int SHIFT_45 = 9;
   localparam int SHIFT_180 = 11;
   localparam logic signed [23:0] POS_MAX = 24'sh0FFFFF;
   localparam logic signed [23:0] POS_MIN = -24'sh100000;

   // ---------------------------------------------------------------
   // Wake input thresholds in millivolts
   // ---------------------------------------------------------------
   localparam int MV_W = 10;
   localparam logic [9:0] RISE_BASE_MV = 10'h12C;
   localparam logic [9:0] RISE_STEP_MV = 10'h032;
   localparam logic [9:0] FALL_FLOOR_MV = 10'h064;
   localparam logic [9:0] HYS_0_MV = 10'h032;
   localparam logic [9:0] HYS_1_MV = 10'h096;
   localparam logic [9:0] HYS_2_MV = 10'h12C;
   localparam logic [9:0] HYS_3_MV = 10'h190;

   // ---------------------------------------------------------------
   // Period counter
   // ---------------------------------------------------------------
   localparam int CYC_W = 24;

   typedef enum logic [2:0] {
      MODE_NORMAL = 3'b001,
      MODE_WAKE = 3'b010,
      MODE_SLEEP = 3'b100
   } mode_t;
endpackage

// *** hdl/turns_step_calc.sv ***
// Angle delta, saturating position update and count extraction
`timescale 1ns/1ps
module turns_step_calc (
   input wire logic [turns_pkg::ANGLE_W-1:0] last_angle,
   input wire logic [turns_pkg::ANGLE_W-1:0] new_angle,
   input wire logic signed [turns_pkg::POS_W-1:0] pos,
   input wire logic step45,
   output logic signed [turns_pkg::POS_W-1:0] next_pos,
   output logic [turns_pkg::COUNT_W-1:0] next_count,
   output logic saturated,
   output logic big_jump,
   output logic [turns_pkg::ANGLE_W-1:0] delta_mag
);
   import turns_pkg::*;
   logic signed [ANGLE_W-1:0] delta;
   logic signed [POS_W:0] sum;

   always_comb begin
      // Wrap makes 180 or more opposite
      delta = $signed(new_angle - last_angle);
      delta_mag = delta[ANGLE_W-1] ? 12'(-delta) : 12'(delta);
      big_jump = delta_mag > JUMP_LIMIT;
      sum = (POS_W+1)'(pos) + (POS_W+1)'(delta);
      saturated = 1'b0;
      if (sum > (POS_W+1)'(POS_MAX)) begin
         next_pos = POS_MAX;
         saturated = 1'b1;
      end else if (sum < (POS_W+1)'(POS_MIN)) begin
         next_pos = POS_MIN;
         saturated = 1'b1;
      end else begin
         next_pos = sum[POS_W-1:0];
      end
      // Step of 45 or 180 degrees
      if (step45) begin
         next_count = 12'(next_pos >>> SHIFT_45);
      end else begin
         next_count = 12'(next_pos >>> SHIFT_180);
      end
   end
endmodule

// *** sim/bemf_source.sv ***
// Filtered back-EMF source driving the wake input level
`timescale 1ns/1ps
module bemf_source (
   input wire logic sys_clk,
   input wire logic [9:0] level,
   output logic [9:0] wake_input_mv
);
   // Level changes just after an edge
   initial begin
      wake_input_mv = 10'h000;
      forever begin
         @(posedge sys_clk);
         wake_input_mv <= #2 level;
      end
   end
endmodule

// *** sim/tb_turns_counter_wake_control.sv ***
// Self-checking bench for the turns counter and wake control block
`timescale 1ns/1ps
module tb_turns_counter_wake_control;
   import turns_pkg::*;
   logic sys_clk, resetn, reg_wr, reg_rd, angle_valid, lpm_request;
   logic angle_outputs_enable, lpm_wake_state, lpm_sleep_state, wake_input_high;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic [11:0] low_power_angle_path, rotation_counts, velocity_limit, ang;
   logic [9:0] wake_input_mv, level, r, f;
   logic [9:0] lv [4];
   logic [9:0] hy [4] = '{HYS_0_MV, HYS_1_MV, HYS_2_MV, HYS_3_MV};
   logic [2:0] wake_input_rising_level_sel;
   logic [1:0] wake_hysteresis_sel;
   logic [23:0] lpm_cycle_cycles;
   logic [27:0] rows [7] = '{28'h0640000, 28'h2640010, 28'h4640020, 28'h0640000, 28'hE64FFF0, 28'h4640020,
      28'hC64FFE8};
   int n_fail, comparisons, i, k;
   turns_counter_wake_control u_dut (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .reg_addr(reg_addr),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .low_power_angle_path(low_power_angle_path),
      .angle_valid(angle_valid),
      .wake_input_mv(wake_input_mv),
      .wake_input_rising_level_sel(wake_input_rising_level_sel),
      .wake_hysteresis_sel(wake_hysteresis_sel),
      .velocity_limit(velocity_limit),
      .lpm_cycle_cycles(lpm_cycle_cycles),
      .lpm_request(lpm_request),
      .rotation_counts(rotation_counts),
      .angle_outputs_enable(angle_outputs_enable),
      .lpm_wake_state(lpm_wake_state),
      .lpm_sleep_state(lpm_sleep_state),
      .wake_input_high(wake_input_high)
   );
   bemf_source u_bemf (
      .sys_clk(sys_clk),
      .level(level),
      .wake_input_mv(wake_input_mv)
   );
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   task automatic tick(input int n = 1);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick();
      reg_wr = 1'b0;
      tick();
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      reg_addr = a;
      reg_rd = 1'b1;
      tick();
      reg_rd = 1'b0;
      check(reg_rdata, exp);
      tick();
   endtask
   task automatic smp(input logic [11:0] a);
      ang = a;
      low_power_angle_path = a;
      angle_valid = 1'b1;
      tick();
      angle_valid = 1'b0;
      tick();
   endtask
   task automatic stop_test;
      $display("mismatches %0d, comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      n_fail++;
      stop_test();
   end
   initial begin
      {resetn, reg_wr, reg_rd, angle_valid, lpm_request} = 5'h00;
      {reg_addr, reg_wdata, low_power_angle_path, level} = 46'h0;
      {wake_input_rising_level_sel, wake_hysteresis_sel} = 5'h00;
      velocity_limit = 12'h300;
      lpm_cycle_cycles = 24'h000010;
      n_fail = 0;
      comparisons = 0;
      tick(20);
      resetn = 1'b1;
      check({12'h000, angle_outputs_enable, lpm_wake_state, lpm_sleep_state, wake_input_high}, 16'h0008);
      rd(DEVICE_CONTROL_OFS, 16'h0100);
      rd(8'h20, 16'h0000);
      for (i = 0; i < 32; i++) begin
         wake_input_rising_level_sel = i[4:2];
         wake_hysteresis_sel = i[1:0];
         r = RISE_BASE_MV + RISE_STEP_MV * 10'(i[4:2]);
         f = (r > hy[i[1:0]] + FALL_FLOOR_MV) ? r - hy[i[1:0]] : FALL_FLOOR_MV;
         lv = '{r, r + 10'h001, f, f - 10'h001};
         for (k = 0; k < 4; k++) begin
            level = lv[k];
            tick(2);
            check({15'h0000, wake_input_high}, {15'h0000, k[0] ^ k[1]});
         end
      end
      for (i = 0; i < 7; i++) begin
         smp(rows[i][27:16]);
         check({4'h0, rotation_counts}, {4'h0, rows[i][15:4]});
         rd(TURNS_WARNING_STATUS_OFS, {12'h000, rows[i][3:0]});
      end
      wr(DEVICE_CONTROL_OFS, 16'h0001);
      check({4'h0, rotation_counts}, 16'h0000);
      rd(TURNS_WARNING_STATUS_OFS, 16'h0000);
      rd(DEVICE_CONTROL_OFS, 16'h0000);
      smp(ang + 12'h400);
      smp(ang + 12'h400);
      check({4'h0, rotation_counts}, 16'h0001);
      for (i = 0; i < 1100; i++) smp(ang - 12'h400);
      check({4'h0, rotation_counts}, 16'h0E00);
      smp(ang + 12'h400);
      rd(TURNS_WARNING_STATUS_OFS, 16'h0001);
      wr(DEVICE_CONTROL_OFS, 16'h0101);
      rd(TURNS_WARNING_STATUS_OFS, 16'h0000);
      for (i = 0; i < 1100; i++) smp(ang + 12'h400);
      wr(8'h1F, 16'h0001);
      check({4'h0, rotation_counts}, 16'h07FF);
      rd(TURNS_WARNING_STATUS_OFS, 16'h0001);
      wr(DEVICE_CONTROL_OFS, 16'h0101);
      lpm_request = 1'b1;
      tick(2);
      check({13'h0000, angle_outputs_enable, lpm_wake_state, lpm_sleep_state}, 16'h0002);
      tick(8);
      check({15'h0000, lpm_wake_state}, 16'h0001);
      for (i = 0; i < 40 && lpm_sleep_state !== 1'b1; i++) tick();
      check({15'h0000, lpm_sleep_state}, 16'h0001);
      smp(ang + 12'h200);
      check({4'h0, rotation_counts}, 16'h0000);
      for (i = 0; i < 20 && lpm_wake_state !== 1'b1; i++) tick();
      check({15'h0000, lpm_wake_state}, 16'h0001);
      smp(ang);
      check({4'h0, rotation_counts}, 16'h0001);
      for (i = 0; i < 40 && lpm_sleep_state !== 1'b1; i++) tick();
      level = 10'h2BC;
      for (i = 0; i < 8 && lpm_wake_state !== 1'b1; i++) tick();
      check({15'h0000, lpm_wake_state}, 16'h0001);
      for (i = 0; i < 20; i++) smp(ang + 12'h200);
      check({3'h0, lpm_wake_state, rotation_counts}, 16'h1015);
      level = 10'h000;
      for (i = 0; i < 40 && lpm_sleep_state !== 1'b1; i++) tick();
      check({15'h0000, lpm_sleep_state}, 16'h0001);
      lpm_request = 1'b0;
      tick();
      check({15'h0000, angle_outputs_enable}, 16'h0001);
      wr(DEVICE_CONTROL_OFS, 16'h0000);
      check({4'h0, rotation_counts}, 16'h0015);
      rd(DEVICE_CONTROL_OFS, 16'h0000);
      resetn = 1'b0;
      tick();
      check({rotation_counts, angle_outputs_enable, lpm_wake_state, lpm_sleep_state, wake_input_high},
         16'h0008);
      resetn = 1'b1;
      rd(DEVICE_CONTROL_OFS, 16'h0100);
      stop_test();
   end
endmodule

// *** sim/turns_cwc_sva.sv ***
// Port assertions for the turns counter and wake control block
`timescale 1ns/1ps
module turns_cwc_sva
   import turns_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic angle_valid,
   input wire logic [9:0] wake_input_mv,
   input wire logic [2:0] wake_input_rising_level_sel,
   input wire logic [1:0] wake_hysteresis_sel,
   input wire logic lpm_request,
   input wire logic [11:0] rotation_counts,
   input wire logic angle_outputs_enable,
   input wire logic lpm_wake_state,
   input wire logic lpm_sleep_state,
   input wire logic wake_input_high
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   localparam logic [9:0] HY [4] = '{HYS_0_MV, HYS_1_MV, HYS_2_MV, HYS_3_MV};
   logic [9:0] rise, fall, hy;
   logic clr, above, keep;
   always_comb begin
      hy = HY[wake_hysteresis_sel];
      rise = RISE_BASE_MV + RISE_STEP_MV * 10'(wake_input_rising_level_sel);
      fall = (rise > hy + FALL_FLOOR_MV) ? rise - hy : FALL_FLOOR_MV;
      above = wake_input_mv > rise;
      keep = wake_input_mv >= fall;
      clr = reg_wr && reg_addr == DEVICE_CONTROL_OFS && reg_wdata[3:0] == TURNS_RESET_CMD;
   end
   sequence s_enter;
      angle_outputs_enable && lpm_request;
   endsequence
   sequence s_wake;
      lpm_wake_state && !angle_outputs_enable && !lpm_sleep_state;
   endsequence
   count_clear_a:
      assert property (clr |=> rotation_counts == 12'h000) else $error("count not cleared");
   count_hold_a:
      assert property ((!angle_valid || lpm_sleep_state) && !clr |=> $stable(rotation_counts)) else $error("count moved");
   lpm_entry_a:
      assert property (s_enter |=> s_wake) else $error("no wake state");
   wake_pin_a:
      assert property (lpm_sleep_state && wake_input_high && lpm_request |=> s_wake) else $error("pin did not wake");
   sleep_guard_a:
      assert property ($rose(lpm_sleep_state) |-> $past(lpm_wake_state) && !$past(wake_input_high))
         else $error("bad sleep entry");
   normal_exit_a:
      assert property (!lpm_request |=> angle_outputs_enable && !lpm_wake_state) else $error("no normal mode");
   rise_level_a:
      assert property (!wake_input_high |=> wake_input_high == $past(above)) else $error("rising level wrong");
   fall_level_a:
      assert property (wake_input_high |=> wake_input_high == $past(keep)) else $error("falling level wrong");
   status_bits_a:
      assert property (reg_rd && reg_addr == TURNS_WARNING_STATUS_OFS |=> reg_rdata[15:4] == 12'h000
         && reg_rdata[2:1] == 2'h0) else $error("status spare bits set");
endmodule
bind turns_counter_wake_control turns_cwc_sva u_sva (
   .sys_clk(sys_clk),
   .resetn(resetn),
   .reg_addr(reg_addr),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata),
   .angle_valid(angle_valid),
   .wake_input_mv(wake_input_mv),
   .wake_input_rising_level_sel(wake_input_rising_level_sel),
   .wake_hysteresis_sel(wake_hysteresis_sel),
   .lpm_request(lpm_request),
   .rotation_counts(rotation_counts),
   .angle_outputs_enable(angle_outputs_enable),
   .lpm_wake_state(lpm_wake_state),
   .lpm_sleep_state(lpm_sleep_state),
   .wake_input_high(wake_input_high)
);
